// ---- verilog/seq_slot_pkg.sv ----
// Behaviour
// - wait bit set: slot value is idle time
// - idle lasts ten ms per count step
// - wait bit clear: slot value is waveform
// - low seven bits index the waveform library
// - go command starts playback at first slot
// - finished waveform advances to next slot
// - stop at zero entry or after eighth
`default_nettype none
package seq_slot_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] SLOT_FIRST_ADDR = 8'h0f;
  localparam logic [7:0] SLOT_LAST_ADDR  = 8'h16;
  localparam logic [7:0] SLOT_TWO_ADDR   = 8'h10;
  localparam logic [7:0] SLOT_THREE_ADDR = 8'h11;
  localparam int         SLOT_COUNT      = 8;
  localparam int         SLOT_WIDTH      = 8;
  localparam int         SLOT_AW         = 3;
  localparam logic [7:0] UNMAPPED_DATA   = 8'h00;
  // ==========================================================
  // slot fields
  localparam int         WAIT_BIT        = 7;
  localparam int         VALUE_MSB       = 6;
  localparam logic [7:0] STOP_ENTRY      = 8'h00;
  localparam logic [6:0] ZERO_VALUE      = 7'h00;
  localparam logic [2:0] LAST_SLOT_IDX   = 3'h7;
  localparam logic [2:0] FIRST_SLOT_IDX  = 3'h0;
  // slot one resets to waveform 1, all others to zero
  localparam logic [63:0] SLOT_RESET_IMAGE = 64'h0000_0000_0000_0001;
  // ==========================================================
  // timing
  localparam int CLK_KHZ        = 250_000;
  localparam int DELAY_STEP_MS  = 10;
  localparam int STEP_CYCLES    = DELAY_STEP_MS * CLK_KHZ;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FETCH  = 3'b001,
    ST_DECIDE = 3'b010,
    ST_PLAY   = 3'b011,
    ST_WAIT   = 3'b100
  } seq_state_e;
endpackage
`default_nettype wire

// ---- verilog/seq_slot_mem.sv ----
`default_nettype none
module seq_slot_mem #(
  parameter int                     WIDTH = 8,
  parameter int                     DEPTH = 8,
  parameter int                     AW    = 3,
  parameter logic [DEPTH*WIDTH-1:0] RESET_IMAGE = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_a_addr,
  output logic      [WIDTH-1:0] rd_a_data,
  input  wire logic [AW-1:0]    rd_b_addr,
  output logic      [WIDTH-1:0] rd_b_data
);
  // ==========================================================
  // storage
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];

  // write port: one word per cycle
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en) begin
      mem_d[wr_addr] = wr_data;
    end
  end

  // reset image is a constant, so the async load stays legal
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= RESET_IMAGE[i*WIDTH +: WIDTH];
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // two registered read ports: bus side and sequencer side
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      rd_a_data <= mem_q[rd_a_addr];
      rd_b_data <= mem_q[rd_b_addr];
    end
  end
endmodule
`default_nettype wire

// ---- verilog/waveform_sequence_slots.sv ----
`default_nettype none
module waveform_sequence_slots #(
  parameter int STEP_CYCLES = seq_slot_pkg::STEP_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       go,
  input  wire logic       wave_done,
  output logic            wave_start,
  output logic      [6:0] wave_index,
  output logic            busy,
  output logic            idle_wait
);
  // ==========================================================
  // register port
  logic       slot_hit;
  logic [2:0] bus_slot;
  logic [7:0] bus_rdata;
  logic       rd_hit_q, rd_hit_d;
  logic       rvalid_q, rvalid_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] slot_data;

  function automatic logic in_slots(input logic [7:0] a);
    return a >= seq_slot_pkg::SLOT_FIRST_ADDR &&
           a <= seq_slot_pkg::SLOT_LAST_ADDR;
  endfunction

  // decode of the eight slot addresses
  assign slot_hit = in_slots(reg_addr);
  assign bus_slot = 3'(reg_addr - seq_slot_pkg::SLOT_FIRST_ADDR);

  seq_slot_mem #(
    .WIDTH       (seq_slot_pkg::SLOT_WIDTH),
    .DEPTH       (seq_slot_pkg::SLOT_COUNT),
    .AW          (seq_slot_pkg::SLOT_AW),
    .RESET_IMAGE (seq_slot_pkg::SLOT_RESET_IMAGE)
  ) u_mem (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .wr_en     (reg_wr && slot_hit),
    .wr_addr   (bus_slot),
    .wr_data   (reg_wdata),
    .rd_a_addr (bus_slot),
    .rd_a_data (bus_rdata),
    .rd_b_addr (idx_q),
    .rd_b_data (slot_data)
  );

  // read answer one cycle after the strobe; unmapped reads zero
  always_comb begin
    rd_hit_d = reg_rd && slot_hit;
    rvalid_d = reg_rd;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_hit_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      rd_hit_q <= rd_hit_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata  = rd_hit_q ? bus_rdata : seq_slot_pkg::UNMAPPED_DATA;
  assign reg_rvalid = rvalid_q;

  // ==========================================================
  // sequencer
  seq_slot_pkg::seq_state_e state_q, state_d;
  logic [6:0]  steps_q, steps_d;
  logic [31:0] div_q, div_d;
  logic        start_q, start_d;
  logic [6:0]  index_q, index_d;
  logic        tick;
  logic        is_wait;
  logic [6:0]  value;

  assign is_wait = slot_data[seq_slot_pkg::WAIT_BIT];
  assign value   = slot_data[seq_slot_pkg::VALUE_MSB:0];
  // step tick only counts inside a wait, so every step is a full one
  assign tick    = (state_q == seq_slot_pkg::ST_WAIT) &&
                   (div_q == 32'(STEP_CYCLES - 1));

  // next state: fetch, decide, then play or idle, then advance
  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    steps_d = steps_q;
    div_d   = div_q;
    start_d = 1'b0;
    index_d = index_q;
    unique case (state_q)
      seq_slot_pkg::ST_IDLE: begin
        if (go) begin
          idx_d   = seq_slot_pkg::FIRST_SLOT_IDX;
          state_d = seq_slot_pkg::ST_FETCH;
        end
      end
      seq_slot_pkg::ST_FETCH: begin
        state_d = seq_slot_pkg::ST_DECIDE; // memory read latency
      end
      seq_slot_pkg::ST_DECIDE: begin
        if (slot_data == seq_slot_pkg::STOP_ENTRY) begin
          state_d = seq_slot_pkg::ST_IDLE;
        end else if (is_wait) begin
          steps_d = value;
          div_d   = '0;
          if (value == seq_slot_pkg::ZERO_VALUE) begin
            state_d = seq_slot_pkg::ST_PLAY; // zero delay: skip at once
          end else begin
            state_d = seq_slot_pkg::ST_WAIT;
          end
        end else begin
          start_d = 1'b1;
          index_d = value;
          state_d = seq_slot_pkg::ST_PLAY;
        end
      end
      seq_slot_pkg::ST_PLAY: begin
        // a zero-length wait passes here without a waveform
        if (wave_done || (is_wait && steps_q == seq_slot_pkg::ZERO_VALUE))
        begin
          if (idx_q == seq_slot_pkg::LAST_SLOT_IDX) begin
            state_d = seq_slot_pkg::ST_IDLE;
          end else begin
            idx_d   = 3'(idx_q + 3'h1);
            state_d = seq_slot_pkg::ST_FETCH;
          end
        end
      end
      seq_slot_pkg::ST_WAIT: begin
        div_d = tick ? '0 : 32'(div_q + 32'h1);
        if (tick) begin
          steps_d = 7'(steps_q - 7'h1);
          if (steps_q == 7'h01) begin
            if (idx_q == seq_slot_pkg::LAST_SLOT_IDX) begin
              state_d = seq_slot_pkg::ST_IDLE;
            end else begin
              idx_d   = 3'(idx_q + 3'h1);
              state_d = seq_slot_pkg::ST_FETCH;
            end
          end
        end
      end
      default: state_d = seq_slot_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= seq_slot_pkg::ST_IDLE;
      idx_q   <= '0;
      steps_q <= '0;
      div_q   <= '0;
      start_q <= 1'b0;
      index_q <= '0;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
      steps_q <= steps_d;
      div_q   <= div_d;
      start_q <= start_d;
      index_q <= index_d;
    end
  end

  assign wave_start = start_q;
  assign wave_index = index_q;
  assign busy       = (state_q != seq_slot_pkg::ST_IDLE);
  assign idle_wait  = (state_q == seq_slot_pkg::ST_WAIT);

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  int unsigned wait_cyc_q;
  int unsigned wait_len_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wait_cyc_q <= 0;
      wait_len_q <= 0;
    end else begin
      if (state_q == seq_slot_pkg::ST_DECIDE) begin
        wait_cyc_q <= 0;
        wait_len_q <= 32'(value);
      end else if (state_q == seq_slot_pkg::ST_WAIT) begin
        wait_cyc_q <= wait_cyc_q + 1;
      end
    end
  end

  sequence decide_wait_s;
    state_q == seq_slot_pkg::ST_DECIDE && is_wait &&
    value != seq_slot_pkg::ZERO_VALUE;
  endsequence
  sequence decide_play_s;
    state_q == seq_slot_pkg::ST_DECIDE && !is_wait &&
    slot_data != seq_slot_pkg::STOP_ENTRY;
  endsequence

  wait_entry_a: assert property (
    decide_wait_s |=> idle_wait && !wave_start)
    else $error("wait slot did not enter idle wait");
  wait_length_a: assert property (
    $fell(idle_wait) |-> wait_cyc_q == wait_len_q * STEP_CYCLES)
    else $error("wait length not steps times step period");
  play_start_a: assert property (
    decide_play_s |=> wave_start ##1 !wave_start)
    else $error("waveform slot did not give one start pulse");
  play_index_a: assert property (
    decide_play_s |=> wave_index == $past(value))
    else $error("waveform index differs from slot value");
  go_first_a: assert property (
    state_q == seq_slot_pkg::ST_IDLE && go |=>
      state_q == seq_slot_pkg::ST_FETCH && idx_q == 3'h0 ##1
      state_q == seq_slot_pkg::ST_DECIDE)
    else $error("go did not start at first slot");
  next_slot_a: assert property (
    state_q == seq_slot_pkg::ST_PLAY && wave_done &&
    idx_q != seq_slot_pkg::LAST_SLOT_IDX |=>
      state_q == seq_slot_pkg::ST_FETCH && idx_q == $past(idx_q) + 3'h1)
    else $error("sequencer did not advance to next slot");
  zero_stop_a: assert property (
    state_q == seq_slot_pkg::ST_DECIDE &&
    slot_data == seq_slot_pkg::STOP_ENTRY |=> !busy)
    else $error("zero entry did not stop sequencer");
  last_stop_a: assert property (
    state_q == seq_slot_pkg::ST_PLAY && wave_done &&
    idx_q == seq_slot_pkg::LAST_SLOT_IDX |=> !busy [*2])
    else $error("sequencer ran past the eighth slot");
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ======================================================
  // signals and model state
  localparam int STEP = 4;  // short wait step keeps the run small
  logic       ref_clk;
  logic       reset;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic       go;
  logic       wave_done;
  logic       wave_start;
  logic [6:0] wave_index;
  logic       busy;
  logic       idle_wait;
  int         error_cnt;
  int         compares;
  int         slot_m [8];
  logic [31:0] lfsr_q;
  // ======================================================
  // design under test
  waveform_sequence_slots #(.STEP_CYCLES(STEP)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .go(go),
    .wave_done(wave_done), .wave_start(wave_start),
    .wave_index(wave_index), .busy(busy), .idle_wait(idle_wait));
  // clock generation, 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ======================================================
  // helpers
  function automatic logic [31:0] next_rand();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction
  task automatic chk(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      error_cnt++;
      $display("BAD t=%0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one-cycle strobes; a spare edge between calls avoids double drives
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    if (a >= 8'h0f && a <= 8'h16) slot_m[a - 8'h0f] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = (a >= 8'h0f && a <= 8'h16) ? 8'(slot_m[a - 8'h0f]) : 8'h00;
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk(reg_rvalid === 1'b1 && reg_rdata === e, "read data");
  endtask
  // waits up to lim falling edges: 0 start, 1 wait level, 2 not busy
  task automatic wait_hi(input int which, input int lim, output bit ok);
    ok = 1'b0;
    repeat (lim) if (!ok) begin
      @(negedge ref_clk);
      case (which)
        0: ok = (wave_start === 1'b1);
        1: ok = (idle_wait === 1'b1);
        default: ok = (busy === 1'b0);
      endcase
    end
  endtask
  task automatic pulse_go();
    @(negedge ref_clk);
    go = 1'b1;
    @(negedge ref_clk);
    go = 1'b0;
  endtask
  // ======================================================
  // plays the programmed slots against the model
  task automatic run_seq();
    int i;
    int n;
    int hi;
    bit ok;
    bit first;
    first = 1'b1;
    pulse_go();
    for (i = 0; i < 8; i++) begin
      if (slot_m[i] == 0) break;
      n = slot_m[i] & 8'h7f;
      if ((slot_m[i] & 8'h80) != 0) begin
        if (n != 0) begin
          // up to seven zero waits may come first, three cycles each
          wait_hi(1, 40, ok);
          hi = 0;
          while (idle_wait === 1'b1 && hi < 1000) begin
            hi++;
            chk(wave_start === 1'b0, "start during wait");
            @(negedge ref_clk);
          end
          chk(ok && hi == n * STEP, "wait length");
        end
      end else begin
        wait_hi(0, 40, ok);
        chk(ok && wave_index === 7'(n), "waveform index");
        if (first) begin
          chk(ok, "first slot start");
          pulse_go(); // ignored while running
        end
        first = 1'b0;
        repeat (next_rand() & 3) @(negedge ref_clk);
        @(negedge ref_clk);
        wave_done = 1'b1;
        @(negedge ref_clk);
        wave_done = 1'b0;
      end
    end
    wait_hi(2, 40, ok);
    chk(ok, "sequence stop");
  endtask
  // ======================================================
  // main sequence
  initial begin
    int i;
    int k;
    logic [31:0] r;
    logic [63:0] fix;
    lfsr_q = 32'h5e1d;
    error_cnt = 0;
    compares = 0;
    reset = 1'b1;
    {reg_addr, reg_wr, reg_wdata, reg_rd, go, wave_done} = '0;
    for (i = 0; i < 8; i++) slot_m[i] = (i == 0) ? 1 : 0;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    // reset values and unmapped read
    for (i = 8'h0f; i <= 8'h17; i++) rd(8'(i));
    $display("test reset values done");
    // random data, unmapped write ignored
    for (i = 8'h0f; i <= 8'h16; i++) wr(8'(i), 8'(next_rand()));
    wr(8'h20, 8'h5a);
    for (i = 8'h0e; i <= 8'h16; i++) rd(8'(i));
    rd(8'h20);
    $display("test register access done");
    // three programs: full eight, stop at slot 5, stop at slot 2
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < 8; i++) begin
        r = next_rand();
        if (i == 8 - 3 * k) wr(8'(8'h0f + i), 8'h00);
        else if (r[1:0] == 2'b00) wr(8'(8'h0f + i), {6'h20, r[9:8]});
        else wr(8'(8'h0f + i), {1'b0, r[14:8] | 7'h01});
      end
      run_seq();
      $display("test sequence %0d done", k);
    end
    // fixed program: timed and zero waits, waveform in the eighth slot
    fix = 64'h3322_8011_8105_8082;
    for (i = 0; i < 8; i++) wr(8'(8'h0f + i), fix[i*8 +: 8]);
    run_seq();
    $display("test fixed sequence done");
    give_verdict();
  end
  // watchdog
  initial begin
    #200us;
    chk(1'b0, "timeout");
    give_verdict();
  end
endmodule
`default_nettype wire
